// File: bus_cond_detect.v
// Pin synchroniser with clock edge and start/stop detection
`timescale 1ns/100ps
module bus_cond_detect (
   input wire core_clk, // Core clock
   input wire rst, // Async reset, active high
   input wire scl_pin, // Raw clock pin
   input wire sda_pin, // Raw data pin level
   output wire sda_lvl, // Synchronised data level
   output wire scl_rise, // Clock rising edge pulse
   output wire scl_fall, // Clock falling edge pulse
   output wire start_det, // Start condition pulse
   output wire stop_det // Stop condition pulse
);
   reg [2:0] scl_ff;
   reg [2:0] sda_ff;

   // Two-stage sync plus one history stage
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         scl_ff <= 3'h7;
         sda_ff <= 3'h7;
      end else begin
         scl_ff <= {scl_ff[1:0], scl_pin};
         sda_ff <= {sda_ff[1:0], sda_pin};
      end
   end

   // Edges and bus conditions from stages 1 and 2 only
   assign sda_lvl = sda_ff[1];
   assign scl_rise = scl_ff[1] & ~scl_ff[2];
   assign scl_fall = ~scl_ff[1] & scl_ff[2];
   assign start_det = scl_ff[1] & scl_ff[2] & ~sda_ff[1] & sda_ff[2];
   assign stop_det = scl_ff[1] & scl_ff[2] & sda_ff[1] & ~sda_ff[2];
endmodule

// File: eeprom_if.v
// Two-wire EEPROM slave interface with bus recovery and write commit
// Function
// - A start followed by a stop returns the interface to idle.
// - In idle, without a start condition the interface keeps its state, whatever the master does.
// - The device pulls the data line low for a zero data bit or an acknowledge.
// - Clocking with data high makes the device drop its acknowledge or read output.
// - The start after the dummy clocks resets the interface, and the master follows with a stop.
// - After power-on clear all commands are ignored until the init interval ends.
// - A stop seen during low supply cancels the pending write.
// - A write starts only after a full data byte and a stop right after its acknowledge.
// - A start aborts the command being received and begins a new one.
`timescale 1ns/100ps
`include "eeprom_if_regs.vh"
module eeprom_if #(
   parameter INIT_CYCLES = `INIT_CYC, // Init interval in core cycles
   parameter WRITE_CYCLES = `WRITE_CYC // Write cycle length in core cycles
) (
   input wire core_clk, // Core clock, 100 MHz
   input wire rst, // Power-on clear, async, active high
   input wire scl_i, // Serial clock pin
   input wire sda_i, // Serial data pin level
   output wire sda_o, // Serial data output value, always low
   output wire sda_oe_n, // Data drive enable, low while driving
   input wire chip_select_bit0, // Address strap bit 0
   input wire chip_select_bit1, // Address strap bit 1
   input wire chip_select_bit2, // Address strap bit 2
   input wire low_supply, // Undervoltage detector, high when low
   output wire standby, // High when idle and ready
   output wire write_busy // High during internal write cycle
);
   localparam ST_INIT = 3'h0;
   localparam ST_IDLE = 3'h1;
   localparam ST_DEV = 3'h2;
   localparam ST_WADR = 3'h3;
   localparam ST_WDAT = 3'h4;
   localparam ST_RDAT = 3'h5;
   localparam ST_BUSY = 3'h6;

   wire sda_lvl;
   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;
   reg [2:0] state_ff;
   reg [3:0] bit_cnt_ff;
   reg ack_ff;
   reg oe_n_ff;
   reg [7:0] shift_ff;
   reg [7:0] ptr_ff;
   reg [7:0] page_data_ff [0:`PAGE_SIZE-1];
   reg [`PAGE_SIZE-1:0] page_valid_ff;
   reg byte_seen_ff;
   reg [`PAGE_BITS:0] cm_idx_ff;
   reg [31:0] timer_ff;
   reg [1:0] low_sync_ff;
   reg [5:0] cs_sync_ff;
   reg [7:0] mem [0:255];
   wire [7:0] rd_byte;
   wire addr_match;
   wire commit_ok;
   wire mem_we;
   wire [7:0] mem_wa;
   integer i;

   // Pin synchronisers and bus condition detection
   bus_cond_detect u_cond (
      .core_clk(core_clk),
      .rst(rst),
      .scl_pin(scl_i),
      .sda_pin(sda_i),
      .sda_lvl(sda_lvl),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_det(start_det),
      .stop_det(stop_det)
   );

   // Two-stage sync of detector and straps
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         low_sync_ff <= 2'h0;
         cs_sync_ff <= 6'h00;
      end else begin
         low_sync_ff <= {low_sync_ff[0], low_supply};
         cs_sync_ff <= {cs_sync_ff[2:0], chip_select_bit2, chip_select_bit1, chip_select_bit0};
      end
   end

   assign rd_byte = mem[ptr_ff];
   assign addr_match = (shift_ff[7:4] == `DEV_TYPE) && (shift_ff[3:1] == cs_sync_ff[5:3]);
   // stop only in data phase, one clock after ack, byte received
   assign commit_ok = (state_ff == ST_WDAT) && !ack_ff && (bit_cnt_ff <= 4'h1) && byte_seen_ff;

   // Main interface sequencer
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_INIT;
         bit_cnt_ff <= 4'h0;
         ack_ff <= 1'b0;
         oe_n_ff <= 1'b1;
         shift_ff <= 8'h00;
         ptr_ff <= 8'h00;
         page_valid_ff <= {`PAGE_SIZE{1'b0}};
         byte_seen_ff <= 1'b0;
         cm_idx_ff <= {(`PAGE_BITS+1){1'b0}};
         timer_ff <= 32'h0;
         for (i = 0; i < `PAGE_SIZE; i = i + 1) begin
            page_data_ff[i] <= 8'h00;
         end
      end else begin
         case (state_ff)
            // ignore all bus activity during init
            ST_INIT: begin
               if (timer_ff >= INIT_CYCLES - 1) begin
                  timer_ff <= 32'h0;
                  state_ff <= ST_IDLE;
               end else begin
                  timer_ff <= timer_ff + 32'h1;
               end
            end
            // array updated only from the committed page
            ST_BUSY: begin
               if (cm_idx_ff < `PAGE_SIZE) begin
                  cm_idx_ff <= cm_idx_ff + 1'b1;
               end
               if (timer_ff >= WRITE_CYCLES - 1) begin
                  timer_ff <= 32'h0;
                  page_valid_ff <= {`PAGE_SIZE{1'b0}};
                  state_ff <= ST_IDLE;
               end else begin
                  timer_ff <= timer_ff + 32'h1;
               end
            end
            default: begin
               if (start_det) begin
                  // start after dummy clocks resets interface
                  state_ff <= ST_DEV;
                  bit_cnt_ff <= 4'h0;
                  ack_ff <= 1'b0;
                  oe_n_ff <= 1'b1;
                  page_valid_ff <= {`PAGE_SIZE{1'b0}};
                  byte_seen_ff <= 1'b0;
               end else if (stop_det) begin
                  ack_ff <= 1'b0;
                  oe_n_ff <= 1'b1;
                  bit_cnt_ff <= 4'h0;
                  byte_seen_ff <= 1'b0;
                  if (commit_ok && !low_sync_ff[1]) begin
                     state_ff <= ST_BUSY;
                     cm_idx_ff <= {(`PAGE_BITS+1){1'b0}};
                     timer_ff <= 32'h0;
                  end else begin
                     state_ff <= ST_IDLE;
                     page_valid_ff <= {`PAGE_SIZE{1'b0}};
                  end
               end else if (state_ff == ST_RDAT) begin
                  if (scl_rise) begin
                     if (bit_cnt_ff == `ACK_SLOT) begin
                        // master nack or data high ends output
                        if (sda_lvl) begin
                           state_ff <= ST_IDLE;
                        end else begin
                           bit_cnt_ff <= 4'h0;
                           shift_ff <= rd_byte;
                        end
                     end else begin
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                     end
                  end else if (scl_fall) begin
                     if (bit_cnt_ff == `ACK_SLOT) begin
                        oe_n_ff <= 1'b1;
                        ptr_ff <= ptr_ff + 8'h01;
                     end else begin
                        // drive low for a zero data bit
                        oe_n_ff <= shift_ff[3'h7 - bit_cnt_ff[2:0]];
                     end
                  end
               end else if (state_ff != ST_IDLE) begin
                  // receive states advance only on bus clocks
                  if (scl_rise && (bit_cnt_ff < `ACK_SLOT)) begin
                     shift_ff <= {shift_ff[6:0], sda_lvl};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end else if (scl_fall && (bit_cnt_ff == `ACK_SLOT)) begin
                     if (!ack_ff) begin
                        if ((state_ff == ST_DEV) && !addr_match) begin
                           state_ff <= ST_IDLE;
                        end else begin
                           ack_ff <= 1'b1;
                           oe_n_ff <= 1'b0;
                           if (state_ff == ST_WADR) begin
                              ptr_ff <= shift_ff;
                           end
                           if (state_ff == ST_WDAT) begin
                              page_data_ff[ptr_ff[`PAGE_BITS-1:0]] <= shift_ff;
                              page_valid_ff[ptr_ff[`PAGE_BITS-1:0]] <= 1'b1;
                              byte_seen_ff <= 1'b1;
                           end
                        end
                     end else begin
                        // Acknowledge done, release and move on
                        ack_ff <= 1'b0;
                        bit_cnt_ff <= 4'h0;
                        oe_n_ff <= 1'b1;
                        case (state_ff)
                           ST_DEV: begin
                              if (shift_ff[0]) begin
                                 state_ff <= ST_RDAT;
                                 shift_ff <= rd_byte;
                                 oe_n_ff <= rd_byte[7];
                              end else begin
                                 state_ff <= ST_WADR;
                              end
                           end
                           ST_WADR: begin
                              state_ff <= ST_WDAT;
                           end
                           ST_WDAT: begin
                              ptr_ff[`PAGE_BITS-1:0] <= ptr_ff[`PAGE_BITS-1:0] + 1'b1;
                           end
                           default: begin
                              state_ff <= ST_IDLE;
                           end
                        endcase
                     end
                  end
               end
            end
         endcase
      end
   end

   // Array write port, one page entry per cycle
   assign mem_we = (state_ff == ST_BUSY) && (cm_idx_ff < `PAGE_SIZE)
                   && page_valid_ff[cm_idx_ff[`PAGE_BITS-1:0]];
   assign mem_wa = {ptr_ff[7:`PAGE_BITS], cm_idx_ff[`PAGE_BITS-1:0]};

   always @(posedge core_clk) begin
      if (mem_we) begin
         mem[mem_wa] <= page_data_ff[cm_idx_ff[`PAGE_BITS-1:0]];
      end
   end

   // Pin and status outputs
   assign sda_o = 1'b0;
   assign sda_oe_n = oe_n_ff;
   assign standby = (state_ff == ST_IDLE);
   assign write_busy = (state_ff == ST_BUSY);
endmodule

// File: eeprom_if_monitor.sv
// Port checker for the EEPROM slave interface
`timescale 1ns/100ps
module eeprom_if_monitor #(
   parameter INIT_CYCLES = 300, // Init length
   parameter WRITE_CYCLES = 40 // Write length
) (
   input wire core_clk, // Clock
   input wire rst, // Reset
   input wire scl_i, // Bus clock
   input wire sda_i, // Bus data
   input wire sda_oe_n, // Drive enable
   input wire low_supply, // Undervoltage
   input wire standby, // Idle flag
   input wire write_busy // Write flag
);
   int cnt;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // Cycles since reset release
   always @(posedge core_clk or posedge rst)
      if (rst) cnt <= 0;
      else if (cnt < INIT_CYCLES + 4) cnt <= cnt + 1;
   a_init_quiet: assert property (cnt < INIT_CYCLES - 1 |-> !standby && sda_oe_n)
      else $error("interface active during init");
   a_init_ends: assert property (cnt == INIT_CYCLES + 3 |-> standby)
      else $error("standby missing after init");
   a_drive_fall: assert property ($changed(sda_oe_n) |-> $past(scl_i, 5) && !$past(scl_i, 2))
      else $error("data drive changed off a clock fall");
   a_hold_high: assert property ($rose(scl_i) |=> $stable(sda_oe_n)[*5])
      else $error("data drive moved while clock high");
   a_write_cause: assert property ($rose(write_busy) |-> scl_i && sda_i && !low_supply)
      else $error("write began without clean stop");
   a_write_hold: assert property ($rose(write_busy) |=> write_busy[*8])
      else $error("write cycle cut short");
   a_busy_deaf: assert property (write_busy |-> sda_oe_n && !standby)
      else $error("bus answered during write");
   a_write_end: assert property ($fell(write_busy) |-> ##[0:2] standby)
      else $error("no standby after write");
   a_stop_idle: assert property (
      cnt > INIT_CYCLES + 3 && scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:6] (standby || write_busy))
      else $error("stop did not return to idle");
   c_write: cover property ($rose(write_busy));
   c_ack: cover property ($fell(sda_oe_n));
   c_ready: cover property ($rose(standby));
endmodule
bind eeprom_if eeprom_if_monitor #(.INIT_CYCLES(INIT_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) u_mon (
   .core_clk(core_clk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i), .sda_oe_n(sda_oe_n),
   .low_supply(low_supply), .standby(standby), .write_busy(write_busy));

// File: eeprom_if_regs.vh
// Constants for the two-wire EEPROM slave interface
`ifndef EEPROM_IF_REGS_VH
`define EEPROM_IF_REGS_VH
// Core clock rate
`define CLK_MHZ 100
// Power-on initialisation interval, microseconds
`define INIT_TIME_US 100
`define INIT_CYC (`INIT_TIME_US * `CLK_MHZ)
// Internal write cycle duration, microseconds
`define WRITE_TIME_US 1000
`define WRITE_CYC (`WRITE_TIME_US * `CLK_MHZ)
// Device type code in the address byte
`define DEV_TYPE 4'hA
// Page size in bytes, as address bits
`define PAGE_BITS 3
`define PAGE_SIZE 8
// Bit count of an acknowledge slot
`define ACK_SLOT 4'h8
`endif

// File: i2c_eeprom_bus_recovery_tb.sv
// Self-checking bench for the EEPROM slave interface
`timescale 1ns/100ps
module i2c_eeprom_bus_recovery_tb;
   logic core_clk = 0, rst = 1, low_supply = 0, ack;
   logic [2:0] cs = 3'h0;
   logic [7:0] mem [256];
   logic [7:0] a, d;
   wire scl, rel, sda_o, oe_n, standby, write_busy;
   wire sda = rel & (oe_n | sda_o);
   int err_total = 0, n_tests = 0, seed = 32'heb38;
   always #5 core_clk = ~core_clk;
   eeprom_if #(.INIT_CYCLES(300), .WRITE_CYCLES(40)) u_dut (.core_clk(core_clk), .rst(rst),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(oe_n), .chip_select_bit0(cs[0]),
      .chip_select_bit1(cs[1]), .chip_select_bit2(cs[2]), .low_supply(low_supply),
      .standby(standby), .write_busy(write_busy));
   i2c_host_model u_m (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_rel(rel));
   function logic [7:0] dev(input logic rw);
      return {4'hA, cs, rw};
   endfunction
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task idle();
      int k;
      k = 0;
      while (standby !== 1'b1 && k < 500) begin
         @(negedge core_clk);
         k++;
      end
      chk(standby, 1);
   endtask
   // Write ending: 0 normal stop, 1 stop mid-byte, 2 start mid-byte
   task wr(input logic [7:0] wa, input logic [7:0] wd, input int cut);
      u_m.start();
      u_m.byte_out(dev(0), ack);
      u_m.byte_out(wa, ack);
      chk(ack, 0);
      if (cut == 0) u_m.byte_out(wd, ack);
      else repeat (4) u_m.bit_out(wd[7]);
      if (cut == 2) u_m.start();
      u_m.stop();
      chk(write_busy, cut == 0 && !low_supply);
      if (cut == 0 && !low_supply) mem[wa] = wd;
      idle();
   endtask
   // dummy write loads the address first
   task rd(input logic [7:0] ra);
      u_m.start();
      u_m.byte_out(dev(0), ack);
      u_m.byte_out(ra, ack);
      u_m.start();
      u_m.byte_out(dev(1), ack);
      u_m.byte_in(1'b1, d);
      u_m.stop();
      chk(d, mem[ra]);
      idle();
   endtask
   task recover();
      u_m.start();
      repeat (9) u_m.bit_out(1'b1);
      chk(sda, 1);
      u_m.start();
      u_m.stop();
      idle();
   endtask
   task complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge core_clk);
      err_total++;
      complete_run();
   end
   // Main sequence
   initial begin
      repeat (20) @(negedge core_clk);
      rst = 0;
      u_m.start();
      u_m.byte_out(dev(0), ack);
      u_m.stop();
      chk(ack, 1);
      idle();
      recover();
      $display("test init done");
      cs = 3'($random(seed));
      wr(8'h10, 8'h00, 0);
      rd(8'h10);
      // Stall a read of the zero byte so the device holds the data line low
      u_m.start();
      u_m.byte_out(dev(0), ack);
      u_m.byte_out(8'h10, ack);
      u_m.start();
      u_m.byte_out(dev(1), ack);
      u_m.bit_in(ack);
      u_m.bit_in(ack);
      chk(sda, 0);
      recover();
      rd(8'h10);
      $display("test recovery done");
      for (int c = 1; c < 3; c++) begin
         wr(8'h10, 8'h5A, c);
         rd(8'h10);
      end
      low_supply = 1;
      wr(8'h10, 8'hA5, 0);
      low_supply = 0;
      rd(8'h10);
      $display("test cancel done");
      repeat (6) begin
         a = 8'($random(seed));
         wr(a, 8'($random(seed)), 0);
         rd(a);
      end
      u_m.start();
      u_m.byte_out({4'hA, ~cs, 1'b0}, ack);
      u_m.stop();
      chk(ack, 1);
      $display("test random done");
      complete_run();
   end
endmodule

// File: i2c_host_model.sv
// Bus master model for the two-wire link
`timescale 1ns/100ps
module i2c_host_model #(parameter H = 8) (
   input wire core_clk, // Clock
   input wire sda, // Resolved data line
   output logic scl = 1'b1, // Bus clock
   output logic sda_rel = 1'b1 // High releases data
);
   // Clock first, data two cycles later, so no false start or stop
   task put(input logic c, input logic d);
      scl = c;
      repeat (2) @(negedge core_clk);
      sda_rel = d;
      repeat (H) @(negedge core_clk);
   endtask
   task start();
      put(0, 1);
      put(1, 1);
      put(1, 0);
      put(0, 0);
   endtask
   task stop();
      put(0, 0);
      put(1, 0);
      put(1, 1);
   endtask
   task bit_out(input logic b);
      put(0, b);
      put(1, b);
   endtask
   task bit_in(output logic b);
      bit_out(1'b1);
      b = sda;
   endtask
   task byte_out(input logic [7:0] v, output logic ack);
      for (int i = 7; i >= 0; i--) bit_out(v[i]);
      bit_in(ack);
   endtask
   task byte_in(input logic m_ack, output logic [7:0] v);
      for (int i = 7; i >= 0; i--) bit_in(v[i]);
      bit_out(m_ack);
   endtask
endmodule
